// >>> include/apm_pkg.sv
// Attribute pixel mapper: register indices, field positions, reset values, types.
// Assumes one dot clock for pixels and host strobes alike.
package apm_pkg;

    // Attribute register indices (5-bit index field)
    localparam logic [4:0] IDX_MAP_BASE  = 5'h00;
    localparam logic [4:0] IDX_MAP_LAST  = 5'h0F;
    localparam logic [4:0] IDX_MODE      = 5'h10;
    localparam logic [4:0] IDX_BORDER    = 5'h11;
    localparam logic [4:0] IDX_PLANE     = 5'h12;
    localparam logic [4:0] IDX_SHIFT     = 5'h13;
    localparam logic [4:0] IDX_UPPER     = 5'h14;

    // Attribute mode control bit positions
    localparam int MODE_P54_SEL    = 7;
    localparam int MODE_PIX8       = 6;
    localparam int MODE_PAN_UPPER  = 5;
    localparam int MODE_BLINK      = 3;
    localparam int MODE_LINE_GR    = 2;
    localparam int MODE_MONO       = 1;
    localparam int MODE_GRAPHICS   = 0;

    // Index port video enable bit
    localparam int IDXP_VIDEO_EN   = 5;

    // Writable bit masks; reserved bits read as zero
    localparam logic [7:0] MASK_INDEX  = 8'h3F;
    localparam logic [7:0] MASK_MAP    = 8'h3F;
    localparam logic [7:0] MASK_MODE   = 8'hEF;
    localparam logic [7:0] MASK_BORDER = 8'hFF;
    localparam logic [7:0] MASK_PLANE  = 8'h3F;
    localparam logic [7:0] MASK_SHIFT  = 8'h0F;
    localparam logic [7:0] MASK_UPPER  = 8'h0F;

    // Reset values
    localparam logic [7:0] RST_INDEX   = 8'h00;
    localparam logic [7:0] RST_MODE    = 8'h00;
    localparam logic [7:0] RST_BORDER  = 8'h00;
    localparam logic [7:0] RST_PLANE   = 8'h0F;
    localparam logic [7:0] RST_SHIFT   = 8'h00;
    localparam logic [7:0] RST_UPPER   = 8'h00;
    localparam logic [5:0] RST_MAP     = 6'h00;

    // Line-drawing character code range and shift codes
    localparam logic [7:0] LINE_CODE_FIRST = 8'hB0;
    localparam logic [7:0] LINE_CODE_LAST  = 8'hDF;
    localparam logic [3:0] SHIFT_NONE_9    = 4'h8;

    // Index/data flip-flop of the attribute port
    typedef enum logic [0:0] {
        PH_INDEX = 1'b0,
        PH_DATA  = 1'b1
    } apm_phase_type;

    // Host port strobes (one cycle each) and write data
    typedef struct packed {
        logic       wr_attr;    // Write to attribute_index_port
        logic       rd_index;   // Read of attribute_index_port
        logic       rd_data;    // Read of the data read port
        logic       rd_status;  // Read of input_status_one
        logic [7:0] wdata;
    } apm_host_type;

    // One pixel slot from the sequencer
    typedef struct packed {
        logic       blank;      // Blanking interval
        logic       line_start; // First slot of a scan line
        logic       lower;      // Slot lies in the lower split region
        logic       nine_dot;   // 9-pixel text cells in use
        logic       col9;       // This slot is the ninth pixel of a cell
        logic       glyph_on;   // Text foreground dot
        logic [7:0] char_code;
        logic [7:0] attr;
        logic [3:0] planes;     // Planar pixel bits 3..0
    } apm_pix_type;

endpackage : apm_pkg

// >>> hdl/apm_fifo.sv
// Output FIFO for palette indices, valid/ready on both sides.
// Assumes DEPTH is a power of two; read data come from the storage registers.
`timescale 1ns/1ps
`default_nettype none
module apm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             resetn,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wp;
        logic [AW:0]                 rp;
    } apm_fifo_state_type;

    apm_fifo_state_type state_ff;
    apm_fifo_state_type nxt_state;
    logic [AW:0]        count;

    // Occupancy flags
    assign count     = state_ff.wp - state_ff.rp;
    assign in_ready  = (count != DEPTH_C);
    assign out_valid = (count != '0);
    assign out_data  = state_ff.mem[state_ff.rp[AW-1:0]];

    // Pointer and storage update
    always_comb
    begin
        nxt_state = state_ff;
        if (in_valid && in_ready)
        begin
            nxt_state.mem[state_ff.wp[AW-1:0]] = in_data;
            nxt_state.wp = state_ff.wp + 1'b1;
        end
        if (out_valid && out_ready)
            nxt_state.rp = state_ff.rp + 1'b1;
    end

    // State register
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            state_ff <= '0;
        else
            state_ff <= nxt_state;
    end
endmodule : apm_fifo
`default_nettype wire

// >>> hdl/apm_attr.sv
// Attribute stage: host attribute port, pixel mapping, blink, pan, border.
// Assumes host strobes and pixel slots are synchronous to clock.
`timescale 1ns/1ps
`default_nettype none
module apm_attr #(
    parameter int FIFO_DEPTH = 16
) (
    // Clock and reset
    input  wire logic                 clock,
    input  wire logic                 resetn,
    // Host attribute port
    input  wire apm_pkg::apm_host_type host,
    output logic [7:0]                host_rdata,
    output logic [1:0]                status_video_bits,
    // Blink timing
    input  wire logic                 vsync,
    input  wire logic [7:0]           blink_rate_setting,
    // Pixel slots from the sequencer
    input  wire logic                 pix_valid,
    output logic                      pix_ready,
    input  wire apm_pkg::apm_pix_type pix,
    // Palette indices to the palette lookup
    output logic                      idx_valid,
    input  wire logic                 idx_ready,
    output logic [7:0]                idx_data
);
    import apm_pkg::*;

    typedef struct packed {
        apm_phase_type   phase;
        logic [7:0]      index;
        logic [15:0][5:0] map;
        logic [7:0]      mode;
        logic [7:0]      border;
        logic [7:0]      plane;
        logic [7:0]      shift;
        logic [7:0]      upper;
        logic [7:0]      rdata;
        logic            vs_d;
        logic [7:0]      blink_cnt;
        logic            blink_on;
        logic [3:0]      skip;
        logic            half;
        logic [3:0]      nib;
        logic            prev_on;
        logic [7:0]      last_idx;
    } apm_state_type;

    apm_state_type state_ff;
    apm_state_type nxt_state;
    logic          push;
    logic [7:0]    push_data;
    logic          fifo_ready;
    logic          video_en;
    logic          accept;
    logic          dropped;

    assign video_en  = state_ff.index[IDXP_VIDEO_EN];
    assign pix_ready = fifo_ready;
    assign accept    = pix_valid && fifo_ready;
    assign host_rdata = state_ff.rdata;

    // Read view of a register, reserved bits zero
    function automatic logic [7:0] read_reg(input apm_state_type s, input logic [4:0] i);
        logic [7:0] r;
        r = 8'h00;
        if (i <= IDX_MAP_LAST)
            r = s.index[IDXP_VIDEO_EN] ? 8'h00 : {2'b00, s.map[i[3:0]]};
        else
            case (i)
                IDX_MODE:   r = s.mode;
                IDX_BORDER: r = s.border;
                IDX_PLANE:  r = s.plane;
                IDX_SHIFT:  r = s.shift;
                IDX_UPPER:  r = s.upper;
                default:    r = 8'h00;
            endcase
        return r;
    endfunction : read_reg

    // Left shift amount for the current mode
    function automatic logic [3:0] pan_amount(input apm_state_type s, input apm_pix_type p);
        logic [3:0] a;
        a = 4'h0;
        if (s.mode[MODE_PAN_UPPER] && p.lower)
            a = 4'h0;
        else if (s.mode[MODE_PIX8])
            a = {2'b00, s.shift[2:1]};
        else if (!s.mode[MODE_GRAPHICS] && p.nine_dot)
            a = (s.shift[3:0] < SHIFT_NONE_9) ? s.shift[3:0] + 4'h1 : 4'h0;
        else
            a = {1'b0, s.shift[2:0]};
        return a;
    endfunction : pan_amount

    // Host port, blink divider and pixel path
    always_comb
    begin
        logic [3:0] fg;
        logic [3:0] bg;
        logic [3:0] v;
        logic [3:0] cnt;
        logic [5:0] e;
        logic       on;
        logic [4:0] wi;
        nxt_state = state_ff;
        push      = 1'b0;
        push_data = 8'h00;
        dropped   = 1'b0;
        fg = 4'h0;
        bg = 4'h0;
        v  = 4'h0;
        e  = 6'h00;
        on = 1'b0;
        cnt = 4'h0;
        wi = state_ff.index[4:0];
        // Attribute port writes alternate index and data
        if (host.wr_attr)
        begin
            if (state_ff.phase == PH_INDEX)
            begin
                nxt_state.index = host.wdata & MASK_INDEX;
                nxt_state.phase = PH_DATA;
            end
            else
            begin
                nxt_state.phase = PH_INDEX;
                if (wi <= IDX_MAP_LAST)
                begin
                    if (!video_en)
                        nxt_state.map[wi[3:0]] = host.wdata[5:0];
                end
                else
                    case (wi)
                        IDX_MODE:   nxt_state.mode   = host.wdata & MASK_MODE;
                        IDX_BORDER: nxt_state.border = host.wdata & MASK_BORDER;
                        IDX_PLANE:  nxt_state.plane  = host.wdata & MASK_PLANE;
                        IDX_SHIFT:  nxt_state.shift  = host.wdata & MASK_SHIFT;
                        IDX_UPPER:  nxt_state.upper  = host.wdata & MASK_UPPER;
                        default:    ;
                    endcase
            end
        end
        // Status read returns the port to index phase
        if (host.rd_status)
            nxt_state.phase = PH_INDEX;
        if (host.rd_index)
            nxt_state.rdata = state_ff.index;
        else if (host.rd_data)
            nxt_state.rdata = read_reg(state_ff, wi);
        // Blink phase flips every rate+1 vsync rising edges
        nxt_state.vs_d = vsync;
        if (vsync && !state_ff.vs_d)
        begin
            if (state_ff.blink_cnt >= blink_rate_setting)
            begin
                nxt_state.blink_cnt = 8'h00;
                nxt_state.blink_on  = !state_ff.blink_on;
            end
            else
                nxt_state.blink_cnt = state_ff.blink_cnt + 8'h01;
        end
        // Pixel slot
        if (accept)
        begin
            cnt = pix.line_start ? pan_amount(state_ff, pix) : state_ff.skip;
            if (pix.blank || !video_en)
            begin
                push      = 1'b1;
                push_data = state_ff.border;
                nxt_state.half = 1'b0;
                nxt_state.skip = pix.line_start ? cnt : state_ff.skip;
            end
            else if (cnt != 4'h0)
            begin
                dropped = 1'b1;
                nxt_state.skip = cnt - 4'h1;
            end
            else
            begin
                nxt_state.skip = 4'h0;
                if (state_ff.mode[MODE_GRAPHICS])
                begin
                    v = pix.planes;
                    if (state_ff.mode[MODE_BLINK] && state_ff.blink_on)
                        v[3] = 1'b0;
                end
                else
                begin
                    if (state_ff.mode[MODE_MONO])
                    begin
                        fg = (pix.attr[2:0] == 3'b000) ? 4'h0 : {pix.attr[3], 3'b111};
                        bg = (pix.attr[6:4] == 3'b111) ? 4'h7 : 4'h0;
                    end
                    else
                    begin
                        fg = pix.attr[3:0];
                        bg = {pix.attr[7] && !state_ff.mode[MODE_BLINK], pix.attr[6:4]};
                    end
                    on = pix.glyph_on;
                    if (pix.col9)
                        on = state_ff.mode[MODE_LINE_GR]
                             && (pix.char_code >= LINE_CODE_FIRST)
                             && (pix.char_code <= LINE_CODE_LAST)
                             && state_ff.prev_on;
                    if (state_ff.mode[MODE_BLINK] && pix.attr[7] && state_ff.blink_on)
                        on = 1'b0;
                    nxt_state.prev_on = on;
                    v = on ? fg : bg;
                end
                v = v & state_ff.plane[3:0];
                if (state_ff.mode[MODE_PIX8])
                begin
                    nxt_state.half = !state_ff.half;
                    nxt_state.nib  = v;
                    if (state_ff.half)
                    begin
                        push      = 1'b1;
                        push_data = {state_ff.nib, v};
                    end
                end
                else
                begin
                    e         = state_ff.map[v];
                    push      = 1'b1;
                    push_data = {state_ff.upper[3:2],
                                 state_ff.mode[MODE_P54_SEL] ? state_ff.upper[1:0] : e[5:4],
                                 e[3:0]};
                end
            end
            if (push)
                nxt_state.last_idx = push_data;
        end
    end

    // State register
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            state_ff        <= '0;
            state_ff.index  <= RST_INDEX;
            state_ff.mode   <= RST_MODE;
            state_ff.border <= RST_BORDER;
            state_ff.plane  <= RST_PLANE;
            state_ff.shift  <= RST_SHIFT;
            state_ff.upper  <= RST_UPPER;
            state_ff.map    <= {16{RST_MAP}};
            state_ff.phase  <= PH_INDEX;
        end
        else
            state_ff <= nxt_state;
    end

    // Status mux picks two bits of the latest index
    always_comb
    begin
        case (state_ff.plane[5:4])
            2'b00:   status_video_bits = {state_ff.last_idx[2], state_ff.last_idx[0]};
            2'b01:   status_video_bits = state_ff.last_idx[5:4];
            2'b10:   status_video_bits = {state_ff.last_idx[3], state_ff.last_idx[1]};
            default: status_video_bits = state_ff.last_idx[7:6];
        endcase
    end

    // Output buffer toward the palette lookup
    apm_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .resetn    (resetn),
        .in_valid  (push),
        .in_ready  (fifo_ready),
        .in_data   (push_data),
        .out_valid (idx_valid),
        .out_ready (idx_ready),
        .out_data  (idx_data)
    );

    // Checks
    property p_status_index;
        @(posedge clock) disable iff (!resetn)
        host.rd_status |=> state_ff.phase == PH_INDEX;
    endproperty
    a_status_index: assert property (p_status_index) else $error("status read left data phase");

    property p_write_toggles;
        @(posedge clock) disable iff (!resetn)
        host.wr_attr && !host.rd_status |=> state_ff.phase != $past(state_ff.phase);
    endproperty
    a_write_toggles: assert property (p_write_toggles) else $error("port write did not toggle");

    property p_read_keeps;
        @(posedge clock) disable iff (!resetn)
        host.rd_data && !host.wr_attr && !host.rd_status |=> $stable(state_ff.phase);
    endproperty
    a_read_keeps: assert property (p_read_keeps) else $error("data read moved the phase");

    property p_border;
        @(posedge clock) disable iff (!resetn)
        accept && pix.blank |-> push && push_data == state_ff.border;
    endproperty
    a_border: assert property (p_border) else $error("blanking did not show border");

    property p_upper_bits;
        @(posedge clock) disable iff (!resetn)
        push && !pix.blank && video_en && !state_ff.mode[MODE_PIX8]
        |-> push_data[7:6] == state_ff.upper[3:2];
    endproperty
    a_upper_bits: assert property (p_upper_bits) else $error("index bits 7-6 wrong");

    property p_alt_bits;
        @(posedge clock) disable iff (!resetn)
        push && !pix.blank && video_en && !state_ff.mode[MODE_PIX8] && state_ff.mode[MODE_P54_SEL]
        |-> push_data[5:4] == state_ff.upper[1:0];
    endproperty
    a_alt_bits: assert property (p_alt_bits) else $error("index bits 5-4 not from select");

    property p_byte_pairs;
        @(posedge clock) disable iff (!resetn)
        accept && !pix.blank && video_en && !dropped && state_ff.mode[MODE_PIX8] && !state_ff.half
        |-> !push ##1 state_ff.half;
    endproperty
    a_byte_pairs: assert property (p_byte_pairs) else $error("byte mode pushed a lone nibble");

    property p_reserved_zero;
        @(posedge clock) disable iff (!resetn)
        host.rd_data && !host.rd_index && state_ff.index[4:0] == IDX_SHIFT |=> host_rdata[7:4] == 4'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero");

    property p_locked_map;
        @(posedge clock) disable iff (!resetn)
        host.wr_attr && state_ff.phase == PH_DATA && video_en && state_ff.index[4:0] <= IDX_MAP_LAST
        |=> $stable(state_ff.map);
    endproperty
    a_locked_map: assert property (p_locked_map) else $error("entry written while video on");
endmodule : apm_attr
`default_nettype wire

// >>> testbench/apm_sink_model.sv
// Palette lookup stand-in: takes indices, stalling at random or on request.
// Assumes the clock and reset of the attribute stage.
`timescale 1ns/1ps
`default_nettype none
module apm_sink_model (
    // Clock and reset
    input  wire logic clock,
    input  wire logic resetn,
    // Stall request from the bench
    input  wire logic hold,
    // Index stream handshake
    output logic      idx_ready
);
    // Ready drops one cycle in four, and stays low while held
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            idx_ready <= 1'b0;
        else
            idx_ready <= !hold && ($urandom % 4 != 0);
    end
endmodule : apm_sink_model
`default_nettype wire

// >>> testbench/testbench.sv
// Self-checking bench for the attribute stage: host port, mapping, border, FIFO.
// Assumes apm_pkg is compiled first and the sink model stalls the output.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import apm_pkg::*;
    logic         clock;
    logic         resetn;
    apm_host_type host;
    logic [7:0]   host_rdata;
    logic [1:0]   status_video_bits;
    logic         vsync;
    logic         pix_valid;
    logic         pix_ready;
    apm_pix_type  pix;
    logic         idx_valid;
    logic         idx_ready;
    logic [7:0]   idx_data;
    logic         hold;
    int           error_cnt;
    int           comparisons;
    logic [7:0]   exp_q[$];
    logic [5:0]   ent[16];
    logic [3:0]   upper;
    logic [7:0]   mode;
    logic [7:0]   e;
    logic [3:0]   nib;
    int           rate;
    logic [7:0]   blink_rate;

    apm_attr #(.FIFO_DEPTH(16)) u_dut (.clock(clock), .resetn(resetn), .host(host),
        .host_rdata(host_rdata), .status_video_bits(status_video_bits), .vsync(vsync),
        .blink_rate_setting(blink_rate), .pix_valid(pix_valid), .pix_ready(pix_ready),
        .pix(pix), .idx_valid(idx_valid), .idx_ready(idx_ready), .idx_data(idx_data));
    apm_sink_model u_sink (.clock(clock), .resetn(resetn), .hold(hold),
        .idx_ready(idx_ready));

    // Dot clock
    always #5 clock = !clock;

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done;
        $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done

    // One host strobe: 0 write, 1 data read, 2 status read
    task automatic host_op(input int kind, input logic [7:0] d);
        @(posedge clock);
        host.wdata <= d;
        host.wr_attr <= (kind == 0);
        host.rd_data <= (kind == 1);
        host.rd_status <= (kind == 2);
        @(posedge clock);
        host <= '0;
    endtask : host_op

    task automatic reg_wr(input logic [7:0] i, input logic [7:0] d);
        host_op(0, i);
        host_op(0, d);
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] i, input logic [7:0] exp);
        host_op(0, i);
        host_op(1, 8'h00);
        #1 check(host_rdata, exp);
        host_op(2, 8'h00);
    endtask : reg_rd

    // Offer one slot and hold it until the FIFO takes it
    task automatic push(input logic [3:0] v, input logic [7:0] a, input logic g, input logic b);
        @(posedge clock);
        pix.planes <= v;
        pix.attr <= a;
        pix.glyph_on <= g;
        pix.blank <= b;
        pix_valid <= 1'b1;
        @(negedge clock);
        while (!pix_ready)
            @(negedge clock);
        @(posedge clock);
        pix_valid <= 1'b0;
    endtask : push

    // Line start with a shift code; only the slots past the shift should come out, as one index
    task automatic pan_case(input logic [7:0] md, input logic [7:0] code, input int slots,
                            input logic [7:0] exp);
        reg_wr(8'h30, md);
        reg_wr(8'h33, code);
        exp_q.push_back(exp);
        pix.line_start <= 1'b1;
        for (int n = 0; n < slots; n++)
        begin
            push(4'(n), {4'h0, 4'(n)}, 1'b1, 1'b0);
            pix.line_start <= 1'b0;
        end
    endtask : pan_case

    // Vertical sync pulses, one clock high each
    task automatic vs_pulses(input int n);
        repeat (n)
        begin
            @(posedge clock);
            vsync <= 1'b1;
            @(posedge clock);
            vsync <= 1'b0;
        end
    endtask : vs_pulses

    task automatic drain;
        while (exp_q.size() != 0)
            @(posedge clock);
        repeat (3) @(posedge clock);
    endtask : drain

    function automatic logic [7:0] map_idx(input logic [3:0] v);
        return {upper[3:2], mode[7] ? upper[1:0] : ent[v][5:4], ent[v][3:0]};
    endfunction : map_idx

    // Compare each index taken by the sink with the oldest note
    always @(posedge clock)
    begin
        if (idx_valid && idx_ready)
            check(idx_data, exp_q.size() != 0 ? exp_q.pop_front() : ~idx_data);
    end

    // Watchdog
    initial
    begin
        #400000;
        error_cnt++;
        test_done();
    end

    // Main sequence
    initial
    begin
        clock = 0; resetn = 0; host = '0; vsync = 0; pix_valid = 0; pix = '0; hold = 0;
        error_cnt = 0; comparisons = 0; blink_rate = 8'h00;
        void'($urandom(32'h5050));
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        host_op(2, 8'h00);
        reg_rd(8'h10, RST_MODE);
        reg_rd(8'h12, RST_PLANE);
        reg_wr(8'h10, 8'hFF);
        reg_rd(8'h10, 8'hEF);
        reg_wr(8'h13, 8'hFF);
        reg_rd(8'h13, 8'h0F);
        host_op(0, 8'h13);
        host_op(1, 8'h00);
        host_op(0, 8'h06);
        reg_rd(8'h13, 8'h06);
        reg_wr(8'h15, 8'hAA);
        reg_rd(8'h15, 8'h00);
        host_op(0, 8'h11);
        host_op(2, 8'h00);
        reg_wr(8'h11, 8'h5A);
        reg_rd(8'h11, 8'h5A);
        for (int i = 0; i < 16; i++)
        begin
            ent[i] = 6'($urandom);
            reg_wr(8'(i), {2'b00, ent[i]});
        end
        reg_wr(8'h25, 8'hFF);
        reg_rd(8'h25, 8'h00);
        reg_rd(8'h05, {2'b00, ent[5]});
        upper = 4'($urandom);
        reg_wr(8'h34, {4'h0, upper});
        reg_wr(8'h33, 8'h00);
        $display("test registers done");
        for (int k = 0; k < 2; k++)
        begin
            mode = k ? 8'h81 : 8'h01;
            reg_wr(8'h30, mode);
            for (int n = 0; n < 16; n++)
            begin
                exp_q.push_back(map_idx(4'(n)));
                push(4'(n), 8'h00, 1'b0, 1'b0);
            end
        end
        reg_wr(8'h32, 8'h05);
        exp_q.push_back(map_idx(4'h5));
        push(4'hF, 8'h00, 1'b0, 1'b0);
        for (int m = 0; m < 4; m++)
        begin
            reg_wr(8'h32, {2'b00, 2'(m), 4'hF});
            nib = 4'($urandom);
            e = map_idx(nib);
            exp_q.push_back(e);
            push(nib, 8'h00, 1'b0, 1'b0);
            drain();
            check({6'h00, status_video_bits}, m == 0 ? {6'h00, e[2], e[0]} : m == 1 ?
                {6'h00, e[5:4]} : m == 2 ? {6'h00, e[3], e[1]} : {6'h00, e[7:6]});
        end
        $display("test mapping done");
        reg_wr(8'h31, 8'hC3);
        exp_q.push_back(8'hC3);
        push(4'h7, 8'h00, 1'b0, 1'b1);
        host_op(0, 8'h00);
        exp_q.push_back(8'hC3);
        push(4'h7, 8'h00, 1'b0, 1'b0);
        host_op(2, 8'h00);
        reg_wr(8'h30, 8'h41);
        exp_q.push_back(8'hA5);
        push(4'hA, 8'h00, 1'b0, 1'b0);
        push(4'h5, 8'h00, 1'b0, 1'b0);
        mode = 8'h00;
        reg_wr(8'h30, mode);
        exp_q.push_back(map_idx(4'hC));
        push(4'h0, 8'h9C, 1'b1, 1'b0);
        exp_q.push_back(map_idx(4'h9));
        push(4'h0, 8'h9C, 1'b0, 1'b0);
        reg_wr(8'h30, 8'h08);
        exp_q.push_back(map_idx(4'h1));
        push(4'h0, 8'h9C, 1'b0, 1'b0);
        reg_wr(8'h31, 8'h00);
        reg_wr(8'h30, 8'h02);
        exp_q.push_back(map_idx(4'h7));
        push(4'h0, 8'h05, 1'b1, 1'b0);
        exp_q.push_back(map_idx(4'h0));
        push(4'h0, 8'h05, 1'b0, 1'b0);
        drain();
        $display("test text and border done");
        pan_case(8'h01, 8'h03, 4, map_idx(4'h3));
        pix.lower <= 1'b1;
        pan_case(8'h01, 8'h03, 4, map_idx(4'h3));
        pan_case(8'h21, 8'h03, 1, map_idx(4'h0));
        pix.lower <= 1'b0;
        pix.nine_dot <= 1'b1;
        pan_case(8'h00, 8'h02, 4, map_idx(4'h3));
        pan_case(8'h00, 8'h08, 1, map_idx(4'h0));
        pix.nine_dot <= 1'b0;
        pan_case(8'h41, 8'h04, 4, 8'h23);
        rate = int'($urandom % 4);
        blink_rate <= 8'(rate);
        reg_wr(8'h30, 8'h09);
        vs_pulses(rate);
        exp_q.push_back(map_idx(4'hF));
        push(4'hF, 8'h00, 1'b0, 1'b0);
        vs_pulses(1);
        exp_q.push_back(map_idx(4'h7));
        push(4'hF, 8'h00, 1'b0, 1'b0);
        reg_wr(8'h30, 8'h08);
        exp_q.push_back(map_idx(4'h1));
        push(4'h0, 8'h9C, 1'b1, 1'b0);
        reg_wr(8'h30, 8'h04);
        exp_q.push_back(map_idx(4'hC));
        push(4'h0, 8'h1C, 1'b1, 1'b0);
        pix.col9 <= 1'b1;
        pix.char_code <= 8'hC4;
        exp_q.push_back(map_idx(4'hC));
        push(4'h0, 8'h1C, 1'b0, 1'b0);
        pix.char_code <= 8'h41;
        exp_q.push_back(map_idx(4'h1));
        push(4'h0, 8'h1C, 1'b0, 1'b0);
        pix.col9 <= 1'b0;
        drain();
        $display("test pan and blink done");
        mode = 8'h01;
        reg_wr(8'h30, mode);
        hold <= 1'b1;
        repeat (3) @(posedge clock);
        for (int n = 0; n < 16; n++)
        begin
            e = 8'($urandom);
            exp_q.push_back(map_idx(e[3:0]));
            push(e[3:0], 8'h00, 1'b0, 1'b0);
        end
        @(negedge clock);
        check({7'h00, pix_ready}, 8'h00);
        hold <= 1'b0;
        drain();
        check(8'(exp_q.size()), 8'h00);
        $display("test buffer done");
        test_done();
    end
endmodule : testbench
`default_nettype wire
